// ### src/card_port_pkg.sv
// Constants shared by the two-wire control port and its card clock generators
//
// Overview of operation
// - Works at 100 kHz and 400 kHz
// - Data change at clock high is control
// - Data fall at clock high is start
// - Data rise at clock high is stop
// - Eight data bits plus ninth acknowledge clock
// - Slave acknowledges every received byte low; an address byte that does not match gets no acknowledge
// - Slave releases data after missing acknowledge
// - Reads continue while master keeps acknowledging
// - Address bit 3 selects card
// - Upper nibble 0100, bits 2:1 from pins
// - Address bit 0 one means read
// - Bit 0 starts or stops session
// - Bit 1 warm reset, hardware clears
// - Bit 2 set picks lower supply
// - Bit 3 power-down with stopped clock
// - Bit 4 sets stopped clock level
// - Bits 6:5 pick divide 8,4,2,1
// - Bit 7 passes card data to host
// - Divider changes never shorten clock pulses
// - Read is address then status bytes
// - Insertion, fault, mute and early flags hold alert low until read
package card_port_pkg;
    localparam int CARD_COUNT = 2;
    localparam logic [3:0] ADDR_FIXED = 4'h4;
    localparam int ADDR_CARD_POS = 3;
    localparam int ADDR_RW_POS = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_SESSION = 0;
    localparam int CTRL_WARM = 1;
    localparam int CTRL_VCC_LOW = 2;
    localparam int CTRL_LOW_POWER = 3;
    localparam int CTRL_IDLE_LEVEL = 4;
    localparam int CTRL_DIV_A = 5;
    localparam int CTRL_DIV_B = 6;
    localparam int CTRL_HOST_PASS = 7;
    localparam int STAT_PRESENT = 0;
    localparam int STAT_INSERTION = 1;
    localparam int STAT_IO_LEVEL = 2;
    localparam int STAT_SUPPLY = 3;
    localparam int STAT_FAULT = 4;
    localparam int STAT_MUTE = 5;
    localparam int STAT_EARLY = 6;
    localparam int STAT_ACTIVE = 7;
    localparam logic SUPPLY_FLAG_RESET = 1'b1;
    localparam logic [1:0] DIV_BY_8 = 2'h0;
    localparam logic [1:0] DIV_BY_4 = 2'h1;
    localparam logic [1:0] DIV_BY_2 = 2'h2;
    localparam logic [1:0] DIV_BY_1 = 2'h3;
    localparam logic [2:0] DIV_WRAP = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// ### src/card_clock_gen.sv
// Card clock generator: divides the synchronised external clock input
`timescale 1ns/1ns
module card_clock_gen
    import card_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic ext_clk_sync,
    input wire logic [1:0] div_sel,
    input wire logic low_power,
    input wire logic idle_level,
    // Card clock
    output logic card_clk
);
    logic ext_prev_reg;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    logic ext_rise;

    assign ext_rise = ext_clk_sync & ~ext_prev_reg;
    assign cnt_next = ext_rise ? cnt_reg + 3'h1 : cnt_reg;
    // All divided phases rise together at the wrap, so a switch there is glitch free
    assign sel_next = (ext_rise && cnt_reg == DIV_WRAP) ? div_sel : sel_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_prev_reg <= 1'b1;
            cnt_reg <= 3'h0;
            sel_reg <= DIV_BY_8;
        end
        else
        begin
            ext_prev_reg <= ext_clk_sync;
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            card_clk <= 1'b0;
        end
        else if (low_power)
        begin
            card_clk <= idle_level;
        end
        else
        begin
            unique case (sel_next)
                DIV_BY_8: card_clk <= ~cnt_next[2];
                DIV_BY_4: card_clk <= ~cnt_next[1];
                DIV_BY_2: card_clk <= ~cnt_next[0];
                DIV_BY_1: card_clk <= ext_clk_sync;
            endcase
        end
    end
endmodule // card_clock_gen

// ### src/card_iface_i2c_control_port.sv
// Two-wire slave control port with per-card control bytes and status flags
`timescale 1ns/1ns
module card_iface_i2c_control_port
    import card_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Address select straps
    input wire logic addr_select_pin_lo,
    input wire logic addr_select_pin_hi,
    // Host alert, active low
    output logic irq_n,
    // Card pins and events per card, plus the shared supervisor fault
    input wire logic [1:0] card_present,
    input wire logic [1:0] card_io_in,
    input wire logic [1:0] external_card_clock_input,
    input wire logic supervisor_fault,
    input wire logic [1:0] fault_trip_event,
    input wire logic [1:0] mute_event,
    input wire logic [1:0] early_event,
    input wire logic [1:0] answer_start,
    input wire logic [1:0] card_active,
    // Card control outputs
    output logic [1:0] session_start,
    output logic [1:0] warm_reset_req,
    output logic [1:0] vcc_low_sel,
    output logic [1:0] low_power,
    output logic [1:0] card_clk,
    // Host side data pins
    output logic [1:0] host_side_data_pin_out,
    output logic [1:0] host_side_data_pin_oe_n
);
    typedef enum logic [2:0] {
        IDLE, ADDR, ADDR_ACK, WRITE, WRITE_ACK, READ, READ_ACK, IGNORE
    } bus_state_t;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int SYNC_W = 10;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic [SYNC_W-1:0] pins;

    assign pins = {addr_select_pin_hi, addr_select_pin_lo, external_card_clock_input,
                   card_io_in, card_present, sda_in, scl_in};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
        end
        else
        begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
        end
    end

    logic scl;
    logic sda;
    logic [1:0] present_s;
    logic [1:0] cio_s;
    logic [1:0] eck_s;
    logic [1:0] pin_addr;

    assign scl = sync_reg[0];
    assign sda = sync_reg[1];
    assign present_s = sync_reg[3:2];
    assign cio_s = sync_reg[5:4];
    assign eck_s = sync_reg[7:6];
    assign pin_addr = {sync_reg[9], sync_reg[8]};

    // ****************************************
    // Bus condition detection
    // ****************************************
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
        end
    end

    // Oversampling at 250 MHz serves both bus rates
    assign scl_rise = scl & ~scl_prev_reg;
    assign scl_fall = ~scl & scl_prev_reg;
    assign start_det = scl & scl_prev_reg & sda_prev_reg & ~sda;
    assign stop_det = scl & scl_prev_reg & ~sda_prev_reg & sda;

    // ****************************************
    // Protocol engine
    // ****************************************
    bus_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] read_snap_reg;
    logic card_sel_reg;
    logic rw_reg;
    logic master_ack_reg;
    logic addr_full_reg;
    logic sda_oe_n_reg;
    logic [7:0] status_byte [CARD_COUNT];
    logic addr_match;
    logic wr_stb;
    logic rd_stb;

    assign addr_match = shift_reg[7:4] == ADDR_FIXED && shift_reg[2:1] == pin_addr;
    assign wr_stb = state_reg == WRITE && scl_fall && bit_cnt_reg == BIT_LAST;
    assign rd_stb = state_reg == READ_ACK && scl_rise;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= IDLE;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            read_snap_reg <= 8'h00;
            card_sel_reg <= 1'b0;
            rw_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            addr_full_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end
        else if (start_det)
        begin
            state_reg <= ADDR;
            bit_cnt_reg <= 3'h0;
            addr_full_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end
        else if (stop_det)
        begin
            state_reg <= IDLE;
            sda_oe_n_reg <= 1'b1;
        end
        else
        begin
            unique case (state_reg)
                IDLE, IGNORE:
                begin
                    sda_oe_n_reg <= 1'b1;
                end
                ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        addr_full_reg <= (bit_cnt_reg == BIT_LAST);
                    end
                    // Bits are counted on rises: the fall that ends the start carries none
                    if (scl_fall && addr_full_reg)
                    begin
                        if (addr_match)
                        begin
                            card_sel_reg <= shift_reg[ADDR_CARD_POS];
                            rw_reg <= shift_reg[ADDR_RW_POS];
                            sda_oe_n_reg <= 1'b0;
                            state_reg <= ADDR_ACK;
                        end
                        else
                        begin
                            state_reg <= IGNORE;
                        end
                    end
                end
                ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= 3'h0;
                        if (rw_reg)
                        begin
                            shift_reg <= status_byte[card_sel_reg];
                            read_snap_reg <= status_byte[card_sel_reg];
                            sda_oe_n_reg <= status_byte[card_sel_reg][7];
                            state_reg <= READ;
                        end
                        else
                        begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= WRITE;
                        end
                    end
                end
                WRITE:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda};
                    end
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == BIT_LAST)
                        begin
                            sda_oe_n_reg <= 1'b0;
                            state_reg <= WRITE_ACK;
                        end
                        else
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        end
                    end
                end
                WRITE_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_n_reg <= 1'b1;
                        bit_cnt_reg <= 3'h0;
                        state_reg <= WRITE;
                    end
                end
                READ:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == BIT_LAST)
                        begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= READ_ACK;
                        end
                        else
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_oe_n_reg <= shift_reg[6];
                        end
                    end
                end
                READ_ACK:
                begin
                    if (scl_rise)
                    begin
                        master_ack_reg <= ~sda;
                    end
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= 3'h0;
                        if (master_ack_reg)
                        begin
                            shift_reg <= status_byte[card_sel_reg];
                            read_snap_reg <= status_byte[card_sel_reg];
                            sda_oe_n_reg <= status_byte[card_sel_reg][7];
                            state_reg <= READ;
                        end
                        else
                        begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    assign sda_oe_n = sda_oe_n_reg;
    assign sda_out = 1'b0;

    // ****************************************
    // Per-card control bytes, status flags and clocks
    // ****************************************
    logic [7:0] ctrl_reg [CARD_COUNT];
    logic [CARD_COUNT-1:0] alert_src;

    for (genvar c = 0; c < CARD_COUNT; c++)
    begin : g_card
        logic present_prev_reg;
        logic insert_reg;
        logic supply_reg;
        logic fault_reg;
        logic mute_reg;
        logic early_reg;
        logic this_read;
        logic warm_clr;

        assign this_read = rd_stb && card_sel_reg == c;
        assign warm_clr = answer_start[c] | (this_read & read_snap_reg[STAT_MUTE]);

        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ctrl_reg[c] <= CTRL_RESET;
            end
            else if (wr_stb && card_sel_reg == c)
            begin
                ctrl_reg[c] <= shift_reg;
            end
            else if (warm_clr)
            begin
                ctrl_reg[c][CTRL_WARM] <= 1'b0;
            end
        end

        // Read clears only what was shown; a new event in the same cycle wins
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                present_prev_reg <= 1'b1;
                insert_reg <= 1'b0;
                supply_reg <= SUPPLY_FLAG_RESET;
                fault_reg <= 1'b0;
                mute_reg <= 1'b0;
                early_reg <= 1'b0;
            end
            else
            begin
                present_prev_reg <= present_s[c];
                insert_reg <= (present_s[c] ^ present_prev_reg) |
                              (insert_reg & ~(this_read & read_snap_reg[STAT_INSERTION]));
                supply_reg <= supervisor_fault |
                              (supply_reg & ~(this_read & read_snap_reg[STAT_SUPPLY]));
                fault_reg <= fault_trip_event[c] |
                             (fault_reg & ~(this_read & read_snap_reg[STAT_FAULT]));
                mute_reg <= mute_event[c] |
                            (mute_reg & ~(this_read & read_snap_reg[STAT_MUTE]));
                early_reg <= early_event[c] |
                             (early_reg & ~(this_read & read_snap_reg[STAT_EARLY]));
            end
        end

        assign status_byte[c] = {card_active[c], early_reg, mute_reg, fault_reg,
                                 supply_reg, cio_s[c], insert_reg, present_s[c]};
        assign alert_src[c] = insert_reg | mute_reg | early_reg | fault_reg;

        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                host_side_data_pin_out[c] <= 1'b1;
                host_side_data_pin_oe_n[c] <= 1'b1;
            end
            else
            begin
                host_side_data_pin_out[c] <= cio_s[c];
                host_side_data_pin_oe_n[c] <= ~ctrl_reg[c][CTRL_HOST_PASS];
            end
        end

        assign session_start[c] = ctrl_reg[c][CTRL_SESSION];
        assign warm_reset_req[c] = ctrl_reg[c][CTRL_WARM];
        assign vcc_low_sel[c] = ctrl_reg[c][CTRL_VCC_LOW];
        assign low_power[c] = ctrl_reg[c][CTRL_LOW_POWER];

        card_clock_gen u_clk (
            .clk(clk),
            .rst_n(rst_n),
            .ext_clk_sync(eck_s[c]),
            .div_sel({ctrl_reg[c][CTRL_DIV_B], ctrl_reg[c][CTRL_DIV_A]}),
            .low_power(ctrl_reg[c][CTRL_LOW_POWER]),
            .idle_level(ctrl_reg[c][CTRL_IDLE_LEVEL]),
            .card_clk(card_clk[c])
        );
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_n <= 1'b1;
        end
        else
        begin
            irq_n <= ~|alert_src;
        end
    end
endmodule // card_iface_i2c_control_port

// ### test/card_port_asserts.sv
// Concurrent checks on the control port pins
`timescale 1ns/1ns
module card_port_asserts
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus and alert
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic irq_n,
    // Card side
    input wire logic [1:0] card_io_in,
    input wire logic [1:0] fault_trip_event,
    input wire logic [1:0] mute_event,
    input wire logic [1:0] early_event,
    input wire logic [1:0] answer_start,
    input wire logic [1:0] session_start,
    input wire logic [1:0] warm_reset_req,
    input wire logic [1:0] vcc_low_sel,
    input wire logic [1:0] low_power,
    input wire logic [1:0] card_clk,
    input wire logic [1:0] host_side_data_pin_out
);
    logic [2:0] run_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles since reset, saturating
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            run_cnt <= 3'h0;
        else if (run_cnt != 3'h7)
            run_cnt <= run_cnt + 3'h1;
    end
    sda_tied_a: assert property (sda_out == 1'b0)
        else $error("sda data not low");
    fault_alert_a: assert property (|fault_trip_event |-> ##[1:3] !irq_n)
        else $error("alert missing after fault");
    event_alert_a: assert property (|(mute_event | early_event) |-> ##[1:3] !irq_n)
        else $error("alert missing after event");
    pass_data_a: assert property (($stable(card_io_in) && run_cnt == 3'h7) [*4]
        |-> host_side_data_pin_out == card_io_in) else $error("host data not following");
    idle_clock_a: assert property ((low_power & $past(low_power) & $past(low_power, 2)
        & (card_clk ^ $past(card_clk))) == 2'h0) else $error("card clock moved in low power");
    pulse_width_a: assert property ($rose(card_clk[0]) && !low_power[0]
        |-> card_clk[0] [*4]) else $error("card clock pulse too short");
    ack_stable_a: assert property (scl_in [*5] |-> $stable(sda_oe_n))
        else $error("data moved while clock high");
    ctrl_update_a: assert property ($changed({session_start, vcc_low_sel, low_power})
        |-> !scl_in && !$past(scl_in)) else $error("control changed at clock high");
    warm_clear_a: assert property (answer_start[1] |-> ##[1:2] !warm_reset_req[1])
        else $error("warm request not cleared");
endmodule // card_port_asserts

bind card_iface_i2c_control_port card_port_asserts u_card_port_asserts (.clk, .rst_n,
    .scl_in, .sda_out, .sda_oe_n, .irq_n, .card_io_in, .fault_trip_event, .mute_event,
    .early_event, .answer_start, .session_start, .warm_reset_req, .vcc_low_sel,
    .low_power, .card_clk, .host_side_data_pin_out);

// ### test/i2c_host_model.sv
// Behavioural two-wire bus master standing for the host
`timescale 1ns/1ns
module i2c_host_model
(
    // From the device
    input wire logic sda_oe_n,
    // Bus lines
    output logic scl,
    output logic sda
);
    int quarter = 625;
    logic pull_low = 1'b0;
    initial scl = 1'b1;
    // Pull-up: line is low if either party pulls
    assign sda = sda_oe_n & ~pull_low;
    task automatic bus_start();
        wait (scl && sda);
        #(quarter) pull_low = 1'b1;
        #(quarter) scl = 1'b0;
    endtask
    task automatic bus_stop();
        pull_low = 1'b1;
        #(quarter) scl = 1'b1;
        #(quarter) pull_low = 1'b0;
        #(2 * quarter);
    endtask
    // Data moves only while the clock is low, a quarter before it rises
    task automatic put_bit(input logic b, output logic seen);
        pull_low = ~b;
        #(quarter) scl = 1'b1;
        #(quarter) seen = sda;
        #(quarter) scl = 1'b0;
        #(quarter);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'b1, ack);
    endtask
    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(~give_ack, s);
    endtask
endmodule // i2c_host_model

// ### test/card_iface_i2c_control_port_tb.sv
// Self-checking bench for the two-wire card control port
`timescale 1ns/1ns
module card_iface_i2c_control_port_tb import card_port_pkg::*;;
    localparam int EXT_HALF = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda, sda_out, sda_oe_n, irq_n, ack, rel;
    logic ext_clk = 1'b0;
    logic [1:0] card_present = 2'h3;
    logic [1:0] fault_trip_event = 2'h0;
    logic [1:0] mute_event = 2'h0;
    logic [1:0] early_event = 2'h0;
    logic [1:0] answer_start = 2'h0;
    logic [1:0] session_start, warm_reset_req, vcc_low_sel, low_power, card_clk;
    logic [1:0] pin_out, pin_oe_n, acks;
    logic [7:0] b1, b2;
    time t0;
    int fails = 0;
    int check_count = 0;
    card_iface_i2c_control_port u_card_iface_i2c_control_port (.clk(clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_select_pin_lo(1'b0), .addr_select_pin_hi(1'b1), .irq_n(irq_n),
        .card_present(card_present), .card_io_in(2'h1),
        .external_card_clock_input({ext_clk, ext_clk}), .supervisor_fault(1'b0),
        .fault_trip_event(fault_trip_event), .mute_event(mute_event),
        .early_event(early_event), .answer_start(answer_start), .card_active(2'h1),
        .session_start(session_start), .warm_reset_req(warm_reset_req),
        .vcc_low_sel(vcc_low_sel), .low_power(low_power), .card_clk(card_clk),
        .host_side_data_pin_out(pin_out), .host_side_data_pin_oe_n(pin_oe_n));
    i2c_host_model u_i2c_host_model (.sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
    initial forever #2 clk = ~clk;
    // Card clock source never stops and keeps one rate
    initial forever #(EXT_HALF) ext_clk = ~ext_clk;
    task automatic compare(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic write_ctrl(input logic [7:0] addr, input logic [7:0] ctrl);
        acks = 2'h3;
        u_i2c_host_model.bus_start();
        u_i2c_host_model.send_byte(addr, acks[1]);
        if (!acks[1])
            u_i2c_host_model.send_byte(ctrl, acks[0]);
        u_i2c_host_model.bus_stop();
    endtask
    task automatic read_stat(input logic [7:0] addr, input logic more);
        u_i2c_host_model.bus_start();
        u_i2c_host_model.send_byte(addr, ack);
        u_i2c_host_model.recv_byte(more, b1);
        if (more)
            u_i2c_host_model.recv_byte(1'b0, b2);
        rel = sda_oe_n;
        u_i2c_host_model.bus_stop();
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        tick(8);
        compare({irq_n, sda_oe_n, pin_oe_n, pin_out, card_clk}, 8'hfc);
        compare({session_start, warm_reset_req, vcc_low_sel, low_power}, 8'h00);
        tick(8);
        rst_n = 1'b1;
        tick(8);
        u_i2c_host_model.quarter = 2500;
        write_ctrl(8'h40, 8'h01);
        u_i2c_host_model.quarter = 625;
        compare({6'h0, acks}, 8'h03);
        compare({6'h0, session_start}, 8'h00);
        write_ctrl(8'h4c, 8'h1e);
        compare({6'h0, acks}, 8'h00);
        compare({session_start, warm_reset_req, vcc_low_sel, low_power}, 8'h2a);
        tick(50);
        compare({7'h0, card_clk[1]}, 8'h01);
        answer_start = 2'h2;
        tick(1);
        answer_start = 2'h0;
        tick(4);
        compare({6'h0, warm_reset_req}, 8'h00);
        u_i2c_host_model.bus_start();
        u_i2c_host_model.send_byte(8'h44, ack);
        compare({7'h0, ack}, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            u_i2c_host_model.send_byte(8'h85 | 8'(k << 5), ack);
            compare({7'h0, ack}, 8'h00);
            tick(200);
            @(posedge card_clk[0]);
            t0 = $time;
            @(posedge card_clk[0]);
            compare(8'(($time - t0) / 4), 8'((8 >> k) * EXT_HALF / 2));
        end
        u_i2c_host_model.bus_stop();
        compare({session_start, warm_reset_req, vcc_low_sel, low_power}, 8'h4e);
        compare({4'h0, pin_oe_n, pin_out}, 8'h09);
        tick(1);
        fault_trip_event = 2'h1;
        mute_event = 2'h1;
        card_present = 2'h2;
        tick(1);
        fault_trip_event = 2'h0;
        mute_event = 2'h0;
        tick(8);
        compare({7'h0, irq_n}, 8'h00);
        read_stat(8'h45, 1'b1);
        compare({6'h0, ack, rel}, 8'h01);
        compare(b1, 8'hbe);
        compare(b2, 8'h84);
        tick(1);
        early_event = 2'h2;
        tick(1);
        early_event = 2'h0;
        read_stat(8'h4d, 1'b0);
        compare(b1 & 8'hfd, 8'h49);
        tick(8);
        compare({7'h0, irq_n}, 8'h01);
        close_out();
    end
    initial
    begin
        // The sequence needs about 400 us
        #420000;
        fails++;
        close_out();
    end
endmodule // card_iface_i2c_control_port_tb
